// ---- hdl/lcdd_defines.svh ----
// Offsets, field positions, reset values and timing counts of the LCD driver command port
// Included by the RAM, link and top files, not by the package; guarded against double inclusion
`ifndef LCDD_DEFINES_SVH
`define LCDD_DEFINES_SVH
// Slave address: upper six bits, lowest bit from the strap
`define LCDD_ADDR_HI 6'h1C
// Display RAM
`define LCDD_PTR_LAST 6'h27
// Command byte fields
`define LCDD_CMD_CONT 7
`define LCDD_CMD_PTR_BIT 6
`define LCDD_CMD_MODE_CODE 2'h2
`define LCDD_CMD_DSEL_CODE 4'hC
`define LCDD_CMD_BLINK_CODE 4'hE
`define LCDD_MODE_PSAVE 4
`define LCDD_MODE_ENABLE 3
`define LCDD_MODE_BIAS 2
`define LCDD_BLINK_EXT 2
// Multiplex codes
`define LCDD_MUX_1TO4 2'h0
`define LCDD_MUX_STATIC 2'h1
`define LCDD_MUX_1TO2 2'h2
`define LCDD_MUX_1TO3 2'h3
// Reset values
`define LCDD_RST_MUX `LCDD_MUX_1TO4
`define LCDD_RST_BIAS 1'h0
`define LCDD_RST_ENABLE 1'h0
`define LCDD_RST_BLINK 2'h0
`define LCDD_RST_PTR 6'h00
`define LCDD_RST_SUB 3'h0
// Timing: rates as printed, counts derived
`define LCDD_SYS_CLK_HZ 125000000
`define LCDD_FCLK_NORM_HZ 190000
`define LCDD_FRAME_HZ 64
`define LCDD_PSAVE_FACTOR 6
`define LCDD_OSC_DIV_NORM (`LCDD_SYS_CLK_HZ / `LCDD_FCLK_NORM_HZ)
`define LCDD_OSC_DIV_SAVE (`LCDD_OSC_DIV_NORM * `LCDD_PSAVE_FACTOR)
`define LCDD_SLOT_NORM (`LCDD_FCLK_NORM_HZ / (`LCDD_FRAME_HZ * 4))
`define LCDD_SLOT_SAVE (`LCDD_SLOT_NORM / `LCDD_PSAVE_FACTOR)
`define LCDD_BLINK_FR1 8'h1F
`define LCDD_BLINK_FR2 8'h3F
`define LCDD_BLINK_FR3 8'h7F
`define LCDD_CLR_CYC 3'h4
`endif

// ---- hdl/lcdd_pkg.sv ----
// Types of the LCD driver command port
// Uses no macros, so needs nothing from lcdd_defines.svh
package lcdd_pkg;
    typedef enum logic [3:0] {
        LNK_FRESH = 4'h1,
        LNK_IGNORE = 4'h2,
        LNK_ADDR = 4'h4,
        LNK_DATA = 4'h8
    } lcdd_link_st_type;

    typedef struct packed {
        lcdd_link_st_type st;
        logic [3:0] cnt;
        logic [7:0] sh;
        logic [7:0] byte_q;
        logic tgl;
        logic ack;
        logic sa0_m;
        logic sa0_s;
    } lcdd_link_type;

    localparam lcdd_link_type LNK_RST = '{st: LNK_FRESH, default: '0};

    typedef struct packed {
        logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
        logic ack_m, ack_s, tgl_m, tgl_s, ext_m, ext_s;
        logic [2:0] sub_m, sub_s;
        logic [2:0] clr_cnt;
        logic lnk_clr, start_seen, msg_act, msg_cmd, tgl_exp;
        logic enable, psave, bias_half;
        logic [1:0] mux;
        logic [5:0] ptr;
        logic [2:0] sub;
        logic blink_ext;
        logic [1:0] blink;
        logic [3:0] wr_left;
        logic [7:0] wr_sh;
        logic ram_we;
        logic [5:0] ram_addr;
        logic [3:0] ram_wd;
        logic [11:0] osc_cnt;
        logic [9:0] slot_cnt;
        logic [1:0] bp, bp_dly;
        logic [7:0] frm_cnt;
        logic blink_off, sda_oe_n, sda_out;
        logic [3:0] bpo;
        logic [39:0] seg;
    } lcdd_state_type;
endpackage

// ---- hdl/lcdd_ram.sv ----
// Display RAM, 40 locations of 4 bits, one bit per backplane
// Written one location per cycle; read as one registered column per backplane
`include "lcdd_defines.svh"
module lcdd_ram (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Write port
    input wire logic i_we,
    input wire logic [5:0] i_addr,
    input wire logic [3:0] i_wd,
    // Column read
    input wire logic [1:0] i_bp,
    output logic [39:0] o_col
);
    genvar gi;
    generate
        for (gi = 0; gi < 40; gi++) begin : g_loc
            logic [3:0] loc_q;
            logic col_q;
            // Cleared on reset so an enabled display never shows a stale pattern
            always_ff @(posedge i_clk) begin
                if (i_sys_rst) begin
                    loc_q <= 4'h0;
                    col_q <= 1'h0;
                end else begin
                    if (i_we && i_addr == 6'(gi)) begin
                        loc_q <= i_wd;
                    end
                    col_q <= loc_q[i_bp];
                end
            end
            assign o_col[gi] = col_q;
        end
    endgenerate
endmodule

// ---- hdl/lcdd_link.sv ----
// Bit receiver of the two-wire port, clocked by the bus clock itself
// Cleared asynchronously by the system side on reset, START and STOP
`include "lcdd_defines.svh"
module lcdd_link (
    // Link clock and clear
    input wire logic i_scl,
    input wire logic i_clr,
    // Data pin and quasi-static levels from the system side
    input wire logic i_sda,
    input wire logic i_sa0,
    input wire logic i_start_seen,
    // Received byte and acknowledge request
    output logic [7:0] o_byte,
    output logic o_byte_tgl,
    output logic o_ack_want
);
    lcdd_pkg::lcdd_link_type q, d;
    logic [7:0] rx;

    // Data is stable while the clock is high, so it is taken on the rising edge
    always_comb begin
        d = q;
        rx = {q.sh[6:0], i_sda};
        d.sa0_m = i_sa0;
        d.sa0_s = q.sa0_m;
        unique case (q.st)
            lcdd_pkg::LNK_FRESH: begin
                if (i_start_seen) begin
                    d.sh = rx;
                    d.cnt = 4'h1;
                    d.st = lcdd_pkg::LNK_ADDR;
                end else begin
                    d.st = lcdd_pkg::LNK_IGNORE;
                end
            end
            lcdd_pkg::LNK_IGNORE: begin
                d.cnt = 4'h0;
            end
            lcdd_pkg::LNK_ADDR: begin
                if (q.cnt == 4'h7) begin
                    d.cnt = 4'h8;
                    // Only a write to our address is answered; reads are refused
                    if (rx[7:1] == {`LCDD_ADDR_HI, q.sa0_s} && !rx[0]) begin
                        d.ack = 1'h1;
                        d.st = lcdd_pkg::LNK_DATA;
                    end else begin
                        d.st = lcdd_pkg::LNK_IGNORE;
                    end
                end else begin
                    d.sh = rx;
                    d.cnt = q.cnt + 4'h1;
                end
            end
            lcdd_pkg::LNK_DATA: begin
                if (q.cnt == 4'h8) begin
                    d.cnt = 4'h0;
                    d.ack = 1'h0;
                end else if (q.cnt == 4'h7) begin
                    d.byte_q = rx;
                    d.tgl = !q.tgl;
                    d.ack = 1'h1;
                    d.cnt = 4'h8;
                end else begin
                    d.sh = rx;
                    d.cnt = q.cnt + 4'h1;
                end
            end
        endcase
    end

    always_ff @(posedge i_scl or posedge i_clr) begin
        if (i_clr) begin
            q <= lcdd_pkg::LNK_RST;
        end else begin
            q <= d;
        end
    end

    assign o_byte = q.byte_q;
    assign o_byte_tgl = q.tgl;
    assign o_ack_want = q.ack;
endmodule

// ---- hdl/lcdd_top.sv ----
// Serial command port and display sequencer of a segment LCD driver
// Bus pins are asynchronous; the open-drain data pin is resolved outside
`include "lcdd_defines.svh"
module lcdd_top (
    // System clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Two-wire bus pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    // Straps and external blink control
    input wire logic i_slave_address_lsb_input,
    input wire logic [2:0] i_sub_addr,
    input wire logic i_blink_ext,
    // Drive settings for the analog section
    output logic [1:0] o_mux_code,
    output logic o_bias_half,
    output logic o_power_save,
    // Display drive
    output logic [3:0] o_bp,
    output logic [39:0] o_seg
);
    lcdd_pkg::lcdd_state_type q, d;
    logic [7:0] lnk_byte;
    logic lnk_tgl;
    logic lnk_ack;
    logic [39:0] ram_col;
    logic start_ev;
    logic stop_ev;
    logic strb;
    logic tick;
    logic slot_end;
    logic [11:0] osc_last;
    logic [9:0] slot_last;
    logic [1:0] bp_last;
    logic [7:0] blink_last;
    logic [3:0] wr_data;
    logic [7:0] wr_next;
    logic vis;

    lcdd_link u_link (
        .i_scl(i_scl),
        .i_clr(q.lnk_clr),
        .i_sda(i_sda),
        .i_sa0(i_slave_address_lsb_input),
        .i_start_seen(q.start_seen),
        .o_byte(lnk_byte),
        .o_byte_tgl(lnk_tgl),
        .o_ack_want(lnk_ack)
    );

    lcdd_ram u_ram (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_we(q.ram_we),
        .i_addr(q.ram_addr),
        .i_wd(q.ram_wd),
        .i_bp(q.bp),
        .o_col(ram_col)
    );

    always_comb begin
        d = q;
        // Two-flop synchronisers for pins and link levels
        d.scl_m = i_scl;
        d.scl_s = q.scl_m;
        d.scl_p = q.scl_s;
        d.sda_m = i_sda;
        d.sda_s = q.sda_m;
        d.sda_p = q.sda_s;
        d.ack_m = lnk_ack;
        d.ack_s = q.ack_m;
        d.tgl_m = lnk_tgl;
        d.tgl_s = q.tgl_m;
        d.sub_m = i_sub_addr;
        d.sub_s = q.sub_m;
        d.ext_m = i_blink_ext;
        d.ext_s = q.ext_m;
        d.sda_out = 1'h0;

        // Bus conditions, seen only while the clock stays high
        start_ev = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
        stop_ev = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;

        // Link clear lasts a few cycles so the returning toggle settles first
        if (q.clr_cnt != 3'h0) begin
            d.clr_cnt = q.clr_cnt - 3'h1;
        end
        if (start_ev) begin
            d.clr_cnt = `LCDD_CLR_CYC;
            d.start_seen = 1'h1;
            d.msg_act = 1'h1;
            d.msg_cmd = 1'h1;
            d.tgl_exp = 1'h0;
            d.sda_oe_n = 1'h1;
        end else if (stop_ev) begin
            d.clr_cnt = `LCDD_CLR_CYC;
            d.start_seen = 1'h0;
            d.msg_act = 1'h0;
            d.msg_cmd = 1'h0;
            d.tgl_exp = 1'h0;
            d.sda_oe_n = 1'h1;
        end
        d.lnk_clr = (d.clr_cnt != 3'h0);

        // Acknowledge is placed and removed on falling clock edges
        if (q.scl_p && !q.scl_s) begin
            d.sda_oe_n = !q.ack_s;
        end

        // Received byte: the link toggle is synchronised, the byte is then stable
        strb = (q.tgl_s != q.tgl_exp) && (q.clr_cnt == 3'h0);
        if (strb) begin
            d.tgl_exp = q.tgl_s;
        end
        if (strb && q.msg_act && q.msg_cmd) begin
            d.msg_cmd = lnk_byte[`LCDD_CMD_CONT];
            if (!lnk_byte[`LCDD_CMD_PTR_BIT]) begin
                d.ptr = lnk_byte[5:0];
            end else if (lnk_byte[6:5] == `LCDD_CMD_MODE_CODE) begin
                d.psave = lnk_byte[`LCDD_MODE_PSAVE];
                d.enable = lnk_byte[`LCDD_MODE_ENABLE];
                d.bias_half = lnk_byte[`LCDD_MODE_BIAS];
                d.mux = lnk_byte[1:0];
            end else if (lnk_byte[6:3] == `LCDD_CMD_DSEL_CODE) begin
                d.sub = lnk_byte[2:0];
            end else if (lnk_byte[6:3] == `LCDD_CMD_BLINK_CODE) begin
                d.blink_ext = lnk_byte[`LCDD_BLINK_EXT];
                d.blink = lnk_byte[1:0];
            end
        end else if (strb && q.msg_act && q.wr_left == 4'h0 && q.sub == q.sub_s) begin
            d.wr_sh = lnk_byte;
            unique case (q.mux)
                `LCDD_MUX_1TO4: d.wr_left = 4'h2;
                `LCDD_MUX_1TO3: d.wr_left = 4'h2;
                `LCDD_MUX_1TO2: d.wr_left = 4'h4;
                `LCDD_MUX_STATIC: d.wr_left = 4'h8;
            endcase
        end

        // Byte to RAM: MSB first lands on backplane 0 of each location
        unique case (q.mux)
            `LCDD_MUX_1TO4: begin
                wr_data = {q.wr_sh[4], q.wr_sh[5], q.wr_sh[6], q.wr_sh[7]};
                wr_next = {q.wr_sh[3:0], 4'h0};
            end
            `LCDD_MUX_1TO3: begin
                wr_data = {1'h0, q.wr_sh[5], q.wr_sh[6], q.wr_sh[7]};
                wr_next = {q.wr_sh[4:0], 3'h0};
            end
            `LCDD_MUX_1TO2: begin
                wr_data = {2'h0, q.wr_sh[6], q.wr_sh[7]};
                wr_next = {q.wr_sh[5:0], 2'h0};
            end
            `LCDD_MUX_STATIC: begin
                wr_data = {3'h0, q.wr_sh[7]};
                wr_next = {q.wr_sh[6:0], 1'h0};
            end
        endcase
        d.ram_we = 1'h0;
        if (q.wr_left != 4'h0) begin
            d.ram_we = 1'h1;
            d.ram_addr = q.ptr;
            d.ram_wd = wr_data;
            d.wr_sh = wr_next;
            d.wr_left = q.wr_left - 4'h1;
            // Pointer moves one location per write; wrap steps the sub-address
            if (q.ptr >= `LCDD_PTR_LAST) begin
                d.ptr = 6'h00;
                d.sub = q.sub + 3'h1;
            end else begin
                d.ptr = q.ptr + 6'h01;
            end
        end

        // Internal clock: divided six times further in power saving
        osc_last = q.psave ? 12'(`LCDD_OSC_DIV_SAVE - 1) : 12'(`LCDD_OSC_DIV_NORM - 1);
        slot_last = q.psave ? 10'(`LCDD_SLOT_SAVE - 1) : 10'(`LCDD_SLOT_NORM - 1);
        tick = (q.osc_cnt >= osc_last);
        d.osc_cnt = tick ? 12'h000 : q.osc_cnt + 12'h001;
        slot_end = tick && (q.slot_cnt >= slot_last);
        if (tick) begin
            d.slot_cnt = slot_end ? 10'h000 : q.slot_cnt + 10'h001;
        end

        // Backplane count follows the multiplex ratio
        unique case (q.mux)
            `LCDD_MUX_1TO4: bp_last = 2'h3;
            `LCDD_MUX_1TO3: bp_last = 2'h2;
            `LCDD_MUX_1TO2: bp_last = 2'h1;
            `LCDD_MUX_STATIC: bp_last = 2'h0;
        endcase
        unique case (q.blink)
            2'h1: blink_last = `LCDD_BLINK_FR1;
            2'h2: blink_last = `LCDD_BLINK_FR2;
            2'h3: blink_last = `LCDD_BLINK_FR3;
            default: blink_last = 8'hFF;
        endcase
        if (slot_end) begin
            if (q.bp >= bp_last) begin
                d.bp = 2'h0;
                // Frame end: blink phase counted in frames
                if (q.frm_cnt >= blink_last) begin
                    d.frm_cnt = 8'h00;
                    d.blink_off = !q.blink_off;
                end else begin
                    d.frm_cnt = q.frm_cnt + 8'h01;
                end
            end else begin
                d.bp = q.bp + 2'h1;
            end
        end
        if (q.blink == 2'h0) begin
            d.blink_off = 1'h0;
            d.frm_cnt = 8'h00;
        end

        // Outputs: column of the RAM arrives one cycle after its backplane
        vis = q.enable && !(q.blink_ext ? q.ext_s : q.blink_off);
        d.bp_dly = q.bp;
        d.seg = vis ? ram_col : 40'h00_0000_0000;
        d.bpo = vis ? (4'h1 << q.bp_dly) : 4'h0;

        if (i_sys_rst) begin
            d = '0;
            d.clr_cnt = `LCDD_CLR_CYC;
            d.lnk_clr = 1'h1;
            d.sda_oe_n = 1'h1;
            d.mux = `LCDD_RST_MUX;
            d.bias_half = `LCDD_RST_BIAS;
            d.enable = `LCDD_RST_ENABLE;
            d.blink = `LCDD_RST_BLINK;
            d.ptr = `LCDD_RST_PTR;
            d.sub = `LCDD_RST_SUB;
        end
    end

    always_ff @(posedge i_clk) begin
        q <= d;
    end

    assign o_sda_out = q.sda_out;
    assign o_sda_oe_n = q.sda_oe_n;
    assign o_mux_code = q.mux;
    assign o_bias_half = q.bias_half;
    assign o_power_save = q.psave;
    assign o_bp = q.bpo;
    assign o_seg = q.seg;
endmodule

// ---- sim/lcdd_top_sva.sv ----
// Concurrent checks on the ports of the LCD driver command port
// Bound to lcdd_top; sees its ports only, all sampled on the system clock
module lcdd_top_sva (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Bus and outputs
    input wire logic i_scl,
    input wire logic o_sda_out,
    input wire logic o_sda_oe_n,
    input wire logic [1:0] o_mux_code,
    input wire logic o_bias_half,
    input wire logic o_power_save,
    input wire logic [3:0] o_bp,
    input wire logic [39:0] o_seg
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    a_sda_low_only: assert property (o_sda_out == 1'b0)
        else $error("data pin drive value not low");
    a_reset_quiet: assert property (disable iff (1'b0)
        i_sys_rst |=> o_sda_oe_n && o_mux_code == 2'h0 && !o_bias_half
        && !o_power_save && o_bp == 4'h0 && o_seg == 40'h0)
        else $error("outputs not at reset state");
    a_ack_starts_low: assert property ($fell(o_sda_oe_n) |-> !i_scl)
        else $error("acknowledge started while clock high");
    a_ack_ends_low: assert property ($rose(o_sda_oe_n) |-> !i_scl)
        else $error("acknowledge ended while clock high");
    a_ack_holds: assert property ($fell(o_sda_oe_n) |-> !o_sda_oe_n [*8])
        else $error("acknowledge too short");
    a_ack_bounded: assert property ($fell(o_sda_oe_n) |-> ##[1:1000] o_sda_oe_n)
        else $error("acknowledge never released");
    a_cmd_before_ack: assert property (
        $changed({o_mux_code, o_bias_half, o_power_save}) |-> o_sda_oe_n)
        else $error("settings changed during acknowledge");
    a_bp_onehot: assert property ($onehot0(o_bp))
        else $error("more than one backplane active");
    a_blank_segs: assert property (o_bp == 4'h0 |-> o_seg == 40'h0)
        else $error("segments driven while blanked");
endmodule

bind lcdd_top lcdd_top_sva u_sva (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_scl(i_scl),
    .o_sda_out(o_sda_out),
    .o_sda_oe_n(o_sda_oe_n),
    .o_mux_code(o_mux_code),
    .o_bias_half(o_bias_half),
    .o_power_save(o_power_save),
    .o_bp(o_bp),
    .o_seg(o_seg)
);

// ---- sim/lcdd_bus_master.sv ----
// Behavioural two-wire bus master writing to the LCD driver
// Assumes a pulled-up data line resolved by the bench; clock idles high between messages
module lcdd_bus_master (
    // Bus lines
    output logic o_scl,
    output logic o_sda,
    input wire logic i_sda
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int QTR = 30;

    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end

    // Data falls while the clock is high
    task automatic start();
        #3 o_sda = 1'b0;
        #(2*QTR) o_scl = 1'b0;
    endtask

    // Data moves only while the clock is low; sampled mid-high
    task automatic bit_cycle(input logic b, output logic got);
        #(QTR) o_sda = b;
        #(QTR) o_scl = 1'b1;
        #(QTR) got = i_sda;
        #(QTR) o_scl = 1'b0;
    endtask

    // Eight bits MSB first, then the line is released for the acknowledge
    task automatic send(input logic [7:0] b, output logic ack);
        logic got;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(b[i], got);
        end
        bit_cycle(1'b1, got);
        ack = (got === 1'b0);
    endtask

    // Data rises while the clock is high
    task automatic stop();
        #(QTR) o_sda = 1'b0;
        #(QTR) o_scl = 1'b1;
        #(2*QTR) o_sda = 1'b1;
    endtask
endmodule

// ---- sim/lcdd_top_tb_top.sv ----
// Self-checking bench of the LCD driver command port
// Drives the bus through lcdd_bus_master; system inputs change by NBA at the clock edge
module lcdd_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_clk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic sa0 = 1'b0;
    logic [2:0] sub_addr = 3'h0;
    logic blink_ext = 1'b0;
    logic scl;
    logic m_sda;
    logic sda_out;
    logic sda_oe_n;
    logic [1:0] mux_code;
    logic bias_half;
    logic power_save;
    logic [3:0] bp;
    logic [39:0] seg;
    logic [7:0] adr;
    int failures = 0;
    int samples_checked = 0;
    wire logic sda_line = m_sda & (sda_oe_n | sda_out);

    initial begin
        forever #4 i_clk = ~i_clk;
    end

    lcdd_top DUT (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_scl(scl),
        .i_sda(sda_line),
        .o_sda_out(sda_out),
        .o_sda_oe_n(sda_oe_n),
        .i_slave_address_lsb_input(sa0),
        .i_sub_addr(sub_addr),
        .i_blink_ext(blink_ext),
        .o_mux_code(mux_code),
        .o_bias_half(bias_half),
        .o_power_save(power_save),
        .o_bp(bp),
        .o_seg(seg)
    );

    lcdd_bus_master u_master (
        .o_scl(scl),
        .o_sda(m_sda),
        .i_sda(sda_line)
    );

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic cmp_ack(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: acknowledge %b, wanted %b", $time, got, exp);
        end
    endtask

    task automatic cmp_out(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: outputs %h, wanted %h", $time, got, exp);
        end
    endtask

    // Settings packed as {mux, bias half, power save}
    task automatic cmp_mode(input logic [3:0] exp);
        cmp_out({mux_code, bias_half, power_save, 44'h0}, {exp, 44'h0});
    endtask

    // Everything packed as {mux, bias half, power save, backplanes, segments}
    task automatic cmp_disp(input logic [47:0] exp);
        cmp_out({mux_code, bias_half, power_save, bp, seg}, exp);
    endtask

    function automatic logic [7:0] mode(input logic c, input logic [3:0] m);
        return {c, 2'b10, m[0], 1'b1, m[1], m[3:2]};
    endfunction

    // One message: START, n bytes from the top of b, STOP
    task automatic xfer(input int n, input logic [31:0] b, input logic [3:0] acks);
        logic a;
        u_master.start();
        for (int i = 0; i < n; i++) begin
            u_master.send(b[31-8*i -: 8], a);
            cmp_ack(a, acks[3-i]);
        end
        u_master.stop();
        repeat (20) @(posedge i_clk);
    endtask

    initial begin
        repeat (40000) @(posedge i_clk);
        failures++;
        end_of_test();
    end

    initial begin
        repeat (12) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        repeat (12) @(posedge i_clk);
        cmp_out({mux_code, bias_half, power_save, bp, seg}, 48'h0);
        cmp_ack(sda_oe_n, 1'b1);
        adr = 8'h70;
        for (int k = 0; k < 4; k++) begin
            xfer(2, {adr, mode(1'b0, 4'(k * 5)), 16'h0}, 4'hC);
            cmp_mode(4'(k * 5));
        end
        sa0 <= 1'b1;
        @(posedge i_clk);
        xfer(2, {adr, mode(1'b0, 4'h6), 16'h0}, 4'h0);
        cmp_mode(4'hF);
        adr = 8'h72;
        xfer(2, {adr | 8'h01, mode(1'b0, 4'h6), 16'h0}, 4'h0);
        cmp_mode(4'hF);
        xfer(4, {adr, mode(1'b1, 4'h6), 8'hF6, mode(1'b0, 4'h9)}, 4'hF);
        cmp_mode(4'h9);
        xfer(4, {adr, 8'hE0, mode(1'b0, 4'h4), mode(1'b0, 4'h3)}, 4'hF);
        cmp_mode(4'h4);
        // Static drive: one data byte fills eight locations, MSB at the pointer
        cmp_disp(48'h4100_0000_003A);
        // Four backplanes: byte splits over two locations from the loaded pointer
        xfer(4, {adr, 8'h8A, mode(1'b0, 4'h0), 8'hAD}, 4'hF);
        cmp_mode(4'h0);
        cmp_disp(48'h0100_0000_0C3A);
        // External blink blanks the backplane and segment outputs while high
        blink_ext <= 1'b1;
        repeat (6) @(posedge i_clk);
        cmp_disp(48'h0);
        blink_ext <= 1'b0;
        repeat (6) @(posedge i_clk);
        cmp_disp(48'h0100_0000_0C3A);
        end_of_test();
    end
endmodule
